// >>> design/seep_slave.sv
// device-side logic of a 128-byte serial eeprom on a four-wire link
`timescale 1ns/1ps
`default_nettype none
module seep_slave
	import seep_pkg::*;
#(
	parameter int WriteCycles = TWC_CYC // shortened in simulation
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic csN,
	input  wire logic sck,
	input  wire logic si,
	input  wire logic wpN,
	input  wire logic holdN,
	output logic      soOut,
	output logic      soOe,
	output logic      writeInProgress
);
	// two-flop synchronisers for all pins
	logic [4:0] syncA;
	logic [4:0] syncB;
	always_ff @(posedge mclk) begin
		syncA <= {holdN, wpN, si, sck, csN};
		syncB <= syncA;
	end
	logic csS, sckS, siS, wpS, holdS;
	assign {holdS, wpS, siS, sckS, csS} = syncB;

	// edge detection state
	logic sckD, csD;
	logic sckRise, sckFall, csRise;
	assign sckRise = sckS & ~sckD;
	assign sckFall = ~sckS & sckD;
	assign csRise = csS & ~csD;

	// array storage and page buffer
	logic [7:0] mem [DEPTH];
	logic [7:0] pageBuf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] pageDirty;

	// protocol state
	seep_phase_e phase, next_phase;
	logic [7:0] shiftIn, next_shiftIn;
	logic [2:0] bitCnt, next_bitCnt;
	logic [2:0] opcode, next_opcode;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [7:0] shiftOut, next_shiftOut;
	logic paused, next_paused;
	logic welatch, next_welatch;
	logic [1:0] bp, next_bp, pendBp, next_pendBp;
	logic gotByte, next_gotByte;
	logic dirtyAny, next_dirtyAny;
	logic stPend, next_stPend;
	logic busy, next_busy;
	logic busySt;
	logic [31:0] busyCnt, next_busyCnt;
	logic [ADDR_W-5:0] wrPage, next_wrPage; // page of the running cycle, addr may move meanwhile
	logic [PAGE_BYTES-1:0] next_pageDirty;
	logic [3:0] pageOff;
	logic [7:0] newByte;
	logic lastBit;
	logic writeOk;

	assign newByte = {shiftIn[6:0], siS};
	assign lastBit = (bitCnt == 3'h7);
	assign pageOff = addr[3:0];

	function automatic logic isProt(input logic [1:0] b, input logic [ADDR_W-1:0] a);
		logic [7:0] ax;
		ax = {1'b0, a};
		case (b)
			2'b00: isProt = 1'b0;
			2'b01: isProt = (ax >= PROT_QUARTER);
			2'b10: isProt = (ax >= PROT_HALF);
			default: isProt = 1'b1;
		endcase
	endfunction

	// writes need latch and protect pin high
	assign writeOk = welatch & wpS;

	// next-state of the serial engine
	always_comb begin
		next_phase = phase;
		next_shiftIn = shiftIn;
		next_bitCnt = bitCnt;
		next_opcode = opcode;
		next_addr = addr;
		next_shiftOut = shiftOut;
		next_paused = paused;
		next_welatch = welatch;
		next_bp = bp;
		next_pendBp = pendBp;
		next_gotByte = gotByte;
		next_dirtyAny = dirtyAny;
		next_stPend = stPend;
		next_busy = busy;
		next_busyCnt = busyCnt;
		next_pageDirty = pageDirty;
		next_wrPage = wrPage;
		busySt = 1'b0;
		if (busy) begin
			if (busyCnt == 32'h0000_0001) begin
				next_busy = 1'b0;
				next_welatch = 1'b0;
				if (stPend) begin
					next_bp = pendBp;
				end
			end else begin
				next_busyCnt = busyCnt - 32'h0000_0001;
			end
		end
		if (csS) begin
			next_phase = SEEP_IDLE;
			next_paused = 1'b0;
			next_bitCnt = '0;
			if (csRise) begin
				// latch commands act on cs rise after full byte
				if (phase == SEEP_DATA && opcode == OP_LSET && gotByte) begin
					next_welatch = 1'b1;
				end else if (phase == SEEP_DATA && opcode == OP_LCLR && gotByte) begin
					next_welatch = 1'b0;
				end else if (!busy && phase == SEEP_DATA && bitCnt == 3'h0 && gotByte && writeOk) begin
					// only a byte-aligned cs rise starts the cycle
					if ((opcode == OP_WRITE && dirtyAny) || (opcode == OP_STWR)) begin
						busySt = 1'b1;
					end
				end
			end
			if (busySt) begin
				next_busy = 1'b1;
				next_busyCnt = 32'(WriteCycles);
				next_stPend = (opcode == OP_STWR);
				next_wrPage = addr[ADDR_W-1:4];
			end
		end else if (!paused) begin
			// pause entered on a low sck level or its falling edge
			if (!holdS && (sckFall || !sckS)) begin
				next_paused = 1'b1;
			end else if (sckRise) begin
				next_shiftIn = newByte;
				next_bitCnt = bitCnt + 3'h1;
				if (lastBit) begin
					case (phase)
						SEEP_IDLE, SEEP_CMD: begin
							next_opcode = newByte[2:0];
							next_gotByte = 1'b0;
							if (!busy) begin
								next_dirtyAny = 1'b0;
								next_pageDirty = '0;
							end
							if (newByte[7:4] != 4'h0) begin
								next_phase = SEEP_SKIP;
							end else if (newByte[2:0] == OP_READ || newByte[2:0] == OP_WRITE) begin
								next_phase = SEEP_ADDR;
							end else if (newByte[2:0] == OP_STRD) begin
								next_phase = SEEP_DATA;
								next_shiftOut = {4'h0, bp, welatch, busy};
							end else begin
								// latch set/clear mark a complete opcode
								next_phase = SEEP_DATA;
								next_gotByte = (newByte[2:0] == OP_LSET || newByte[2:0] == OP_LCLR);
							end
						end
						SEEP_ADDR: begin
							next_addr = newByte[ADDR_W-1:0];
							next_phase = SEEP_DATA;
							next_shiftOut = busy ? 8'hFF : mem[newByte[ADDR_W-1:0]];
						end
						SEEP_DATA: begin
							if (opcode == OP_READ) begin
								// pointer increments with natural 7-bit wrap
								next_addr = addr + 7'h01;
								next_shiftOut = busy ? 8'hFF : mem[addr + 7'h01];
							end else if (opcode == OP_WRITE && !busy) begin
								// low nibble wraps inside the page
								next_pageDirty[pageOff] = ~isProt(bp, addr);
								next_dirtyAny = dirtyAny | ~isProt(bp, addr);
								next_addr = {addr[ADDR_W-1:4], pageOff + 4'h1};
								next_gotByte = 1'b1;
							end else if (opcode == OP_STWR && !busy) begin
								next_pendBp = newByte[ST_BP_HI:ST_BP_LO];
								next_gotByte = 1'b1;
							end else if (opcode == OP_STRD) begin
								// status refreshed every byte for polling
								next_shiftOut = {4'h0, bp, welatch, busy};
							end else begin
								next_gotByte = 1'b0;
							end
						end
						default: next_phase = SEEP_SKIP;
					endcase
				end else if (phase == SEEP_IDLE) begin
					next_phase = SEEP_CMD;
				end
				// extra bits after a latch command spoil it
				if (!lastBit && phase == SEEP_DATA && (opcode == OP_LSET || opcode == OP_LCLR)) begin
					next_gotByte = 1'b0;
				end
			end else if (sckFall && (phase == SEEP_DATA) && bitCnt != 3'h0) begin
				next_shiftOut = {shiftOut[6:0], 1'b1};
			end
		end else begin
			// resume only while sck is low
			if (holdS && (sckFall || !sckS)) begin
				next_paused = 1'b0;
			end
		end
		// protect pin low clears the latch; cycle untouched
		if (!wpS) begin
			next_welatch = 1'b0;
		end
	end

	// register the serial engine
	always_ff @(posedge mclk) begin
		sckD <= sckS;
		csD <= csS;
		if (rst) begin
			phase <= SEEP_IDLE;
			shiftIn <= 8'h00;
			bitCnt <= 3'h0;
			opcode <= 3'h0;
			addr <= 7'h00;
			shiftOut <= 8'h00;
			paused <= 1'b0;
			welatch <= 1'b0; // latch cleared at power-up
			bp <= 2'h0;
			pendBp <= 2'h0;
			gotByte <= 1'b0;
			dirtyAny <= 1'b0;
			stPend <= 1'b0;
			busy <= 1'b0;
			busyCnt <= 32'h0000_0000;
			wrPage <= '0;
			pageDirty <= '0;
		end else begin
			phase <= next_phase;
			shiftIn <= next_shiftIn;
			bitCnt <= next_bitCnt;
			opcode <= next_opcode;
			addr <= next_addr;
			shiftOut <= next_shiftOut;
			paused <= next_paused;
			welatch <= next_welatch;
			bp <= next_bp;
			pendBp <= next_pendBp;
			gotByte <= next_gotByte;
			dirtyAny <= next_dirtyAny;
			stPend <= next_stPend;
			busy <= next_busy;
			busyCnt <= next_busyCnt;
			wrPage <= next_wrPage;
			pageDirty <= next_pageDirty;
		end
	end

	// page buffer captures each data byte, array committed at cycle end
	// one process owns the array; no capture while busy so the running cycle keeps its page
	always_ff @(posedge mclk) begin
		if (sckRise && lastBit && !csS && !paused && !busy && phase == SEEP_DATA && opcode == OP_WRITE) begin
			pageBuf[pageOff] <= newByte;
		end
		// commit only when a valid cycle ends, into the page latched at its start
		for (int i = 0; i < PAGE_BYTES; i++) begin
			if (busy && busyCnt == 32'h0000_0001 && !stPend && pageDirty[i]) begin
				mem[{wrPage, 4'(i)}] <= pageBuf[i];
			end
		end
	end

	// output drive only while selected, active and not held
	assign soOe = ~csS & holdS & (phase == SEEP_DATA)
		& (opcode == OP_READ || opcode == OP_STRD);
	assign soOut = shiftOut[7];
	// progress bit also as a pin
	assign writeInProgress = busy;

	// latch only rises on a cs rising edge
	chk_latch_on_cs: assert property (@(posedge mclk) disable iff (rst)
		$rose(welatch) |-> $past(csRise)) else $error("latch set without cs rise");
	// latch low while protect pin low
	chk_wp_latch: assert property (@(posedge mclk) disable iff (rst)
		!$past(wpS) |-> !welatch) else $error("latch set under write protect");
	chk_latch_end: assert property (@(posedge mclk) disable iff (rst)
		$fell(busy) && !$past(csRise) |-> !welatch) else $error("latch kept after write cycle");
	chk_so_desel: assert property (@(posedge mclk) disable iff (rst)
		csS |-> !soOe) else $error("so driven while deselected");
	chk_so_hold: assert property (@(posedge mclk) disable iff (rst)
		!holdS |-> !soOe) else $error("so driven during hold");
	chk_busy_runs: assert property (@(posedge mclk) disable iff (rst)
		busy && busyCnt > 32'h0000_0001 |=> busy) else $error("write cycle cut short");
	// cycle starts only on cs rise
	chk_busy_start: assert property (@(posedge mclk) disable iff (rst)
		$rose(busy) |-> $past(csRise)) else $error("write cycle without cs rise");
	// paused engine holds its bit count
	chk_pause_hold: assert property (@(posedge mclk) disable iff (rst)
		paused && !csS |=> $stable(bitCnt)) else $error("bit count moved in pause");
endmodule
`default_nettype wire

// >>> inc/seep_pkg.sv
// constants for the serial eeprom slave
package seep_pkg;
	// array geometry
	localparam int ADDR_W = 7;
	localparam int DEPTH = 128;
	localparam int PAGE_BYTES = 16;
	// opcode low nibble, bit 3 ignored, upper nibble zero
	localparam logic [2:0] OP_READ = 3'h3;
	localparam logic [2:0] OP_WRITE = 3'h2;
	localparam logic [2:0] OP_STWR = 3'h1;
	localparam logic [2:0] OP_LSET = 3'h6;
	localparam logic [2:0] OP_LCLR = 3'h4;
	localparam logic [2:0] OP_STRD = 3'h5;
	// status bit positions
	localparam int ST_WIP = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 3;
	// protected ranges: lowest protected address per block-protect code
	localparam logic [7:0] PROT_QUARTER = 8'h60;
	localparam logic [7:0] PROT_HALF = 8'h40;
	// write cycle time in ms, and clock rate
	localparam int TWC_MS = 5;
	localparam int MCLK_KHZ = 200_000;
	localparam int TWC_CYC = TWC_MS * MCLK_KHZ;
	// frame phases
	typedef enum logic [2:0] {
		SEEP_IDLE = 3'b000,
		SEEP_CMD  = 3'b001,
		SEEP_ADDR = 3'b011,
		SEEP_DATA = 3'b010,
		SEEP_SKIP = 3'b110
	} seep_phase_e;
endpackage

// >>> dv/seep_host.sv
// host side of the serial link
`timescale 1ns/1ps
`default_nettype none
module seep_host (
	input  wire logic mclk,
	input  wire logic soOut,
	input  wire logic soOe,
	output var logic  csN,
	output var logic  sck,
	output var logic  si,
	output var logic  holdN
);
	// link idle: deselected, clock parked low
	initial begin
		csN = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		holdN = 1'b1;
	end
	// 16 mclk per half period gives 80 ns
	task automatic half();
		repeat (16) @(negedge mclk);
	endtask
	task automatic on();
		csN = 1'b0;
		half();
	endtask
	// deselect ends a frame; si flips so no stale level
	task automatic off();
		csN = 1'b1;
		si = ~si;
		half();
		half();
	endtask
	// msb first, sample so at rising edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int nb = 8);
		rx = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			si = tx[i];
			half();
			sck = 1'b1;
			// released line reads as the inverse, so a missing drive shows up
			rx[i] = soOe ? soOut : ~soOut;
			half();
			sck = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
// bench for the serial eeprom slave
`timescale 1ns/1ps
`default_nettype none
module tb;
	import seep_pkg::*;
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic       wpN = 1'b1;
	wire        csN, sck, si, holdN, soOut, soOe, write_in_progress;
	int         n_fail = 0;
	int         compares = 0;
	logic [7:0] mem [int]; // model array, written places only
	logic       write_enable_latch = 1'b0;
	logic [1:0] bp = 2'b00;
	logic [31:0] lf = 32'hd22b_4f76;
	logic [7:0] rx;
	always #2.5 mclk = ~mclk;
	// short write cycle keeps the run brief
	seep_slave #(.WriteCycles(2000)) i_seep_slave (.mclk(mclk), .rst(rst), .csN(csN), .sck(sck),
		.si(si), .wpN(wpN), .holdN(holdN), .soOut(soOut), .soOe(soOe), .writeInProgress(write_in_progress));
	seep_host host (.mclk(mclk), .soOut(soOut), .soOe(soOe), .csN(csN), .sck(sck), .si(si),
		.holdN(holdN));
	function automatic logic [7:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[7:0];
	endfunction
	function automatic logic prot(logic [6:0] p);
		return bp == 2'd3 || (bp == 2'd2 && p >= 7'h40) || (bp == 2'd1 && p >= 7'h60);
	endfunction
	task automatic chk(logic [7:0] seen, logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("n_fail %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmd(logic [7:0] op);
		host.on();
		host.xfer(op, rx);
		host.off();
		if (op[7:4] == 4'h0 && op[2:0] == OP_LSET && wpN) write_enable_latch = 1'b1;
		if (op[7:4] == 4'h0 && op[2:0] == OP_LCLR) write_enable_latch = 1'b0;
	endtask
	task automatic stat();
		host.on();
		host.xfer(8'h05, rx);
		host.xfer(rnd(), rx);
		host.off();
	endtask
	task automatic st();
		stat();
		chk(rx, {4'h0, bp, write_enable_latch, 1'b0});
	endtask
	// bounded poll for the write cycle to end
	task automatic idle();
		int i;
		for (i = 0; i < 4000 && write_in_progress !== 1'b0; i++)
			@(negedge mclk);
		if (i == 4000) begin
			n_fail++;
			stop_test();
		end
	endtask
	task automatic wr(logic [7:0] op, logic [7:0] a, int n, int cut);
		logic [7:0] d;
		logic [6:0] p;
		host.on();
		host.xfer(op, rx);
		host.xfer(a, rx);
		for (int i = 0; i < n; i++) begin
			d = rnd();
			p = {a[6:4], a[3:0] + 4'(i)};
			host.xfer(d, rx);
			if (write_enable_latch && wpN && cut == 0 && !prot(p)) mem[p] = d;
		end
		if (cut > 0) host.xfer(rnd(), rx, cut);
		host.off();
		if (write_enable_latch && wpN && cut == 0) begin
			if (op[2:0] == OP_STWR) bp = a[3:2];
			write_enable_latch = 1'b0;
		end
	endtask
	task automatic rd(logic [7:0] op, logic [7:0] a, int n, logic busy);
		logic [6:0] p;
		p = a[6:0];
		host.on();
		host.xfer(op, rx);
		host.xfer(a, rx);
		for (int i = 0; i < n; i++) begin
			host.xfer(rnd(), rx);
			if (busy) chk(rx, 8'hff); // refused while busy
			else if (mem.exists(p)) chk(rx, mem[p]); // stream
			p++;
		end
		host.off();
		chk({7'h0, soOe}, 8'h00); // released when deselected
	endtask
	initial begin
		repeat (100000) @(posedge mclk);
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		st(); // clean after reset
		cmd(8'h06);
		st(); // latch set
		cmd(8'h04);
		st(); // latch cleared
		cmd(8'h16);
		st(); // nonzero upper nibble ignored
		cmd(8'h0E);
		wr(8'h02, 8'h1E, 18, 0);
		chk({7'h0, write_in_progress}, 8'h01); // cycle runs after cs rise
		rd(8'h03, 8'h1E, 1, 1);
		stat();
		chk({7'h0, rx[0]}, 8'h01); // busy bit
		idle();
		st(); // latch cleared at end
		rd(8'h0B, 8'h90, 16, 0); // page wrap
		cmd(8'h06);
		wr(8'h0A, 8'h7E, 2, 0);
		wpN = 1'b0;
		idle();
		wpN = 1'b1;
		cmd(8'h06);
		wr(8'h02, 8'h00, 1, 0);
		idle();
		rd(8'h03, 8'h7E, 3, 0); // wrap to zero
		wpN = 1'b0;
		cmd(8'h06);
		st(); // latch held clear
		wr(8'h02, 8'h1F, 1, 0);
		idle();
		wpN = 1'b1;
		rd(8'h03, 8'h1F, 1, 0); // array untouched
		cmd(8'h06);
		wr(8'h02, 8'h11, 1, 3);
		idle();
		rd(8'h03, 8'h11, 1, 0); // ragged write dropped
		wr(8'h02, 8'h60, 2, 0);
		idle();
		cmd(8'h04);
		cmd(8'h06);
		wr(8'h09, 8'h04, 0, 0);
		idle();
		st(); // quarter protect
		for (int k = 0; k < 2; k++) begin
			cmd(8'h06);
			wr(8'h02, k ? 8'h20 : 8'h60, 2, 0);
			idle();
		end
		rd(8'h03, 8'h60, 2, 0); // upper quarter kept
		host.on();
		host.xfer(8'h03, rx);
		host.xfer(8'h20, rx);
		host.holdN = 1'b0;
		repeat (5) @(negedge mclk);
		chk({7'h0, soOe}, 8'h00); // off on hold
		host.holdN = 1'b1;
		repeat (5) @(negedge mclk);
		chk({7'h0, soOe}, 8'h01); // back on release
		host.xfer(rnd(), rx);
		chk(rx, mem[32]); // sequence kept
		host.off();
		stop_test();
	end
endmodule
`default_nettype wire
